// File: logic/ipm_pkg.sv
// shared constants, modes and carriers of the ipv6 ace field matcher
package ipm_pkg;

    // register byte offsets
    localparam int IPM_ADDR_W = 8;
    localparam logic [7:0] IPM_OFF_CTRL = 8'h00;
    localparam logic [7:0] IPM_OFF_SPORT = 8'h04;
    localparam logic [7:0] IPM_OFF_DPORT = 8'h08;
    localparam logic [7:0] IPM_OFF_MODE = 8'h0C;
    localparam logic [7:0] IPM_OFF_FLAGS = 8'h10;
    localparam logic [7:0] IPM_OFF_VALS = 8'h14;
    localparam logic [7:0] IPM_OFF_STAT = 8'h18;

    // field positions
    localparam int IPM_CTRL_EN_POS = 0;
    localparam int IPM_CTRL_DENY_POS = 1;
    localparam int IPM_PORT_LO_POS = 0;
    localparam int IPM_PORT_HI_POS = 16;
    localparam int IPM_MODE_SP_POS = 0;
    localparam int IPM_MODE_DP_POS = 2;
    localparam int IPM_MODE_TOS_POS = 4;
    localparam int IPM_MODE_ID_POS = 6;
    localparam int IPM_MODE_CODE_POS = 7;
    localparam int IPM_VALS_DSCP_POS = 0;
    localparam int IPM_VALS_PREC_POS = 8;
    localparam int IPM_VALS_ID_POS = 16;
    localparam int IPM_VALS_CODE_POS = 24;
    localparam int IPM_STAT_HIT_POS = 16;
    localparam int IPM_STAT_DROP_POS = 17;

    // reset values
    localparam logic [31:0] IPM_RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] IPM_RST_SPORT = 32'hFFFF_0000;
    localparam logic [31:0] IPM_RST_DPORT = 32'hFFFF_0000;
    localparam logic [31:0] IPM_RST_MODE = 32'h0000_0000;
    localparam logic [31:0] IPM_RST_FLAGS = 32'h0000_0000;
    localparam logic [31:0] IPM_RST_VALS = 32'h0000_0000;

    // protocol and bus codes
    localparam int IPM_NUM_FLAGS = 6;
    localparam logic [7:0] IPM_PROTO_TCP = 8'h06;
    localparam logic [1:0] IPM_RESP_OKAY = 2'h0;
    localparam logic [1:0] IPM_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IPM_PORT_ANY = 2'h0,
        IPM_PORT_SINGLE = 2'h1,
        IPM_PORT_RANGE = 2'h2
    } ipm_port_mode_e;

    typedef enum logic [1:0] {
        IPM_FLAG_DONT_CARE = 2'h0,
        IPM_FLAG_SET = 2'h1,
        IPM_FLAG_UNSET = 2'h2
    } ipm_flag_sel_e;

    typedef enum logic [1:0] {
        IPM_TOS_ANY = 2'h0,
        IPM_TOS_DSCP = 2'h1,
        IPM_TOS_PREC = 2'h2
    } ipm_tos_mode_e;

    // fields of one received frame; tcp_flags is urg,ack,psh,rst,syn,fin
    typedef struct packed {
        logic [15:0] sport;
        logic [15:0] dport;
        logic [5:0] tcp_flags;
        logic [7:0] tclass;
        logic [7:0] next_hdr;
        logic [7:0] icmp_code;
    } ipm_frame_s;

    // contents of one access control entry
    typedef struct packed {
        logic enable;
        logic deny;
        ipm_port_mode_e sp_mode;
        logic [15:0] sp_lo;
        logic [15:0] sp_hi;
        ipm_port_mode_e dp_mode;
        logic [15:0] dp_lo;
        logic [15:0] dp_hi;
        logic [11:0] flag_sel;
        ipm_tos_mode_e tos_mode;
        logic [5:0] dscp;
        logic [2:0] prec;
        logic id_en;
        logic [7:0] icmp_id;
        logic code_en;
        logic [7:0] icmp_code;
    } ipm_ace_s;

endpackage

// File: logic/ipm_match.sv
// combinational test of one entry against one frame
`timescale 1ns/1ps
module ipm_match
    import ipm_pkg::*;
(
    // entry and frame
    input ipm_ace_s ace,
    input ipm_frame_s frm,
    // result
    output logic hit
);

    // port test shared by source and destination
    function automatic logic port_ok(input ipm_port_mode_e mode,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi,
                                     input logic [15:0] port);
        logic ok;
        ok = 1'b1;
        case (mode)
            IPM_PORT_SINGLE: ok = (port == lo);
            IPM_PORT_RANGE: ok = (port >= lo) && (port <= hi);
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    logic sp_ok;
    logic dp_ok;
    logic flags_ok;
    logic tos_ok;
    logic id_ok;
    logic code_ok;
    logic is_tcp;

    // port criteria; lo above hi leaves an empty range
    assign sp_ok = port_ok(ace.sp_mode, ace.sp_lo, ace.sp_hi, frm.sport);
    assign dp_ok = port_ok(ace.dp_mode, ace.dp_lo, ace.dp_hi, frm.dport);
    assign is_tcp = (frm.next_hdr == IPM_PROTO_TCP);

    // each flag judged on its own selector
    always_comb begin
        flags_ok = 1'b1;
        for (int i = 0; i < IPM_NUM_FLAGS; i++) begin
            case (ipm_flag_sel_e'(ace.flag_sel[2*i +: 2]))
                IPM_FLAG_SET:
                    if (!is_tcp || !frm.tcp_flags[i]) flags_ok = 1'b0;
                IPM_FLAG_UNSET:
                    if (is_tcp && frm.tcp_flags[i]) flags_ok = 1'b0;
                default: flags_ok = flags_ok;
            endcase
        end
    end

    // traffic class, icmp id and code
    always_comb begin
        case (ace.tos_mode)
            IPM_TOS_DSCP: tos_ok = (frm.tclass[7:2] == ace.dscp);
            IPM_TOS_PREC: tos_ok = (frm.tclass[7:5] == ace.prec);
            default: tos_ok = 1'b1;
        endcase
    end
    assign id_ok = !ace.id_en || (frm.next_hdr == ace.icmp_id);
    assign code_ok = !ace.code_en || (frm.icmp_code == ace.icmp_code);

    // all enabled criteria together
    assign hit = ace.enable && sp_ok && dp_ok && flags_ok && tos_ok &&
                 id_ok && code_ok;

endmodule

// File: logic/ipm_top.sv
// ipv6 ace field matcher with axi4-lite register slave
// How it works
// - source range matches only inside bounds
// - destination any ignores destination port
// - destination single equals, range lies within
// - six separate three-way tcp flag selectors
// - set flag needs tcp with bit one
// - unset flag refuses tcp with bit one
// - don't care flag accepts both values
// - tos any skips traffic class
// - dscp mode needs equal six-bit code
// - precedence mode needs equal three bits
// - icmp id enabled needs next_hdr equal to the identifier
// - icmp code any skips code field
// - icmp code defined needs equal code
// - hit on deny entry drops frame
// - hit on permit entry forwards, learns
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ipm_top
    import ipm_pkg::*;
(
    // clock and reset
    input logic clk,
    input logic nrst,
    // axi4-lite write channels
    input logic [IPM_ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // axi4-lite read channels
    input logic [IPM_ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // parsed frame in
    input logic frm_valid,
    input ipm_frame_s frm,
    // verdict out, one cycle after frm_valid
    output logic res_valid,
    output logic res_hit,
    output logic res_drop,
    output logic res_fwd,
    output logic res_learn
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [IPM_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [31:0] sport;
        logic [31:0] dport;
        logic [31:0] mode;
        logic [31:0] flags;
        logic [31:0] vals;
        logic [15:0] hit_cnt;
        logic last_hit;
        logic last_drop;
        logic res_valid;
        logic res_hit;
        logic res_drop;
        logic res_fwd;
        logic res_learn;
    } ipm_state_s;

    ipm_state_s q_q;
    ipm_state_s q_d;
    ipm_ace_s ace;
    logic m_hit;
    logic aw_fire;
    logic w_fire;

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = val[8*b +: 8];
        end
        return r;
    endfunction

    // mapped address check, used for reads and writes
    function automatic logic mapped(input logic [IPM_ADDR_W-1:0] a);
        logic m;
        if (a == IPM_OFF_CTRL) m = 1'b1;
        else if (a == IPM_OFF_SPORT) m = 1'b1;
        else if (a == IPM_OFF_DPORT) m = 1'b1;
        else if (a == IPM_OFF_MODE) m = 1'b1;
        else if (a == IPM_OFF_FLAGS) m = 1'b1;
        else if (a == IPM_OFF_VALS) m = 1'b1;
        else if (a == IPM_OFF_STAT) m = 1'b1;
        else m = 1'b0;
        return m;
    endfunction

    // entry fields unpacked from the registers
    assign ace.enable = q_q.ctrl[IPM_CTRL_EN_POS];
    assign ace.deny = q_q.ctrl[IPM_CTRL_DENY_POS];
    assign ace.sp_mode = ipm_port_mode_e'(q_q.mode[IPM_MODE_SP_POS +: 2]);
    assign ace.sp_lo = q_q.sport[IPM_PORT_LO_POS +: 16];
    assign ace.sp_hi = q_q.sport[IPM_PORT_HI_POS +: 16];
    assign ace.dp_mode = ipm_port_mode_e'(q_q.mode[IPM_MODE_DP_POS +: 2]);
    assign ace.dp_lo = q_q.dport[IPM_PORT_LO_POS +: 16];
    assign ace.dp_hi = q_q.dport[IPM_PORT_HI_POS +: 16];
    assign ace.flag_sel = q_q.flags[11:0];
    assign ace.tos_mode = ipm_tos_mode_e'(q_q.mode[IPM_MODE_TOS_POS +: 2]);
    assign ace.dscp = q_q.vals[IPM_VALS_DSCP_POS +: 6];
    assign ace.prec = q_q.vals[IPM_VALS_PREC_POS +: 3];
    assign ace.id_en = q_q.mode[IPM_MODE_ID_POS];
    assign ace.icmp_id = q_q.vals[IPM_VALS_ID_POS +: 8];
    assign ace.code_en = q_q.mode[IPM_MODE_CODE_POS];
    assign ace.icmp_code = q_q.vals[IPM_VALS_CODE_POS +: 8];

    // criteria evaluation
    ipm_match u_match (
        .ace(ace),
        .frm(frm),
        .hit(m_hit)
    );

    assign aw_fire = s_axi_awvalid && q_q.awready;
    assign w_fire = s_axi_wvalid && q_q.wready;

    // next state: bus slave, entry registers, verdict
    always_comb begin
        q_d = q_q;
        if (aw_fire) begin
            q_d.aw_have = 1'b1;
            q_d.awaddr = s_axi_awaddr;
        end
        if (w_fire) begin
            q_d.w_have = 1'b1;
            q_d.wdata = s_axi_wdata;
            q_d.wstrb = s_axi_wstrb;
        end
        if (q_q.bvalid && s_axi_bready) begin
            q_d.bvalid = 1'b0;
        end
        if (q_d.aw_have && q_d.w_have) begin
            q_d.aw_have = 1'b0;
            q_d.w_have = 1'b0;
            q_d.bvalid = 1'b1;
            q_d.bresp = mapped(q_d.awaddr) ? IPM_RESP_OKAY : IPM_RESP_SLVERR;
            if (q_d.awaddr == IPM_OFF_CTRL) begin
                q_d.ctrl = merge(q_q.ctrl, q_d.wdata, q_d.wstrb);
            end else if (q_d.awaddr == IPM_OFF_SPORT) begin
                q_d.sport = merge(q_q.sport, q_d.wdata, q_d.wstrb);
            end else if (q_d.awaddr == IPM_OFF_DPORT) begin
                q_d.dport = merge(q_q.dport, q_d.wdata, q_d.wstrb);
            end else if (q_d.awaddr == IPM_OFF_MODE) begin
                q_d.mode = merge(q_q.mode, q_d.wdata, q_d.wstrb);
            end else if (q_d.awaddr == IPM_OFF_FLAGS) begin
                q_d.flags = merge(q_q.flags, q_d.wdata, q_d.wstrb);
            end else if (q_d.awaddr == IPM_OFF_VALS) begin
                q_d.vals = merge(q_q.vals, q_d.wdata, q_d.wstrb);
            end
        end
        q_d.awready = !q_d.aw_have && !q_d.bvalid;
        q_d.wready = !q_d.w_have && !q_d.bvalid;
        // read channel, answer one cycle after the address
        if (q_q.rvalid && s_axi_rready) begin
            q_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q_q.arready) begin
            q_d.rvalid = 1'b1;
            q_d.rresp = mapped(s_axi_araddr) ? IPM_RESP_OKAY : IPM_RESP_SLVERR;
            if (s_axi_araddr == IPM_OFF_CTRL) begin
                q_d.rdata = {30'h0, q_q.ctrl[1:0]};
            end else if (s_axi_araddr == IPM_OFF_SPORT) begin
                q_d.rdata = q_q.sport;
            end else if (s_axi_araddr == IPM_OFF_DPORT) begin
                q_d.rdata = q_q.dport;
            end else if (s_axi_araddr == IPM_OFF_MODE) begin
                q_d.rdata = {24'h0, q_q.mode[7:0]};
            end else if (s_axi_araddr == IPM_OFF_FLAGS) begin
                q_d.rdata = {20'h0, q_q.flags[11:0]};
            end else if (s_axi_araddr == IPM_OFF_VALS) begin
                q_d.rdata = q_q.vals & 32'hFFFF_073F;
            end else if (s_axi_araddr == IPM_OFF_STAT) begin
                q_d.rdata = {14'h0, q_q.last_drop, q_q.last_hit, q_q.hit_cnt};
            end else begin
                q_d.rdata = 32'h0000_0000;
            end
        end
        q_d.arready = !q_d.rvalid;
        // verdict for the frame presented this cycle
        q_d.res_valid = frm_valid;
        q_d.res_hit = frm_valid && m_hit;
        q_d.res_drop = frm_valid && m_hit && ace.deny;
        q_d.res_fwd = frm_valid && !(m_hit && ace.deny);
        q_d.res_learn = frm_valid && !(m_hit && ace.deny);
        if (frm_valid) begin
            q_d.last_hit = m_hit;
            q_d.last_drop = m_hit && ace.deny;
            if (m_hit) q_d.hit_cnt = q_q.hit_cnt + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_q <= '0;
            q_q.awready <= 1'b1;
            q_q.wready <= 1'b1;
            q_q.arready <= 1'b1;
            q_q.ctrl <= IPM_RST_CTRL;
            q_q.sport <= IPM_RST_SPORT;
            q_q.dport <= IPM_RST_DPORT;
            q_q.mode <= IPM_RST_MODE;
            q_q.flags <= IPM_RST_FLAGS;
            q_q.vals <= IPM_RST_VALS;
        end else begin
            q_q <= q_d;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = q_q.awready;
    assign s_axi_wready = q_q.wready;
    assign s_axi_bresp = q_q.bresp;
    assign s_axi_bvalid = q_q.bvalid;
    assign s_axi_arready = q_q.arready;
    assign s_axi_rdata = q_q.rdata;
    assign s_axi_rresp = q_q.rresp;
    assign s_axi_rvalid = q_q.rvalid;
    assign res_valid = q_q.res_valid;
    assign res_hit = q_q.res_hit;
    assign res_drop = q_q.res_drop;
    assign res_fwd = q_q.res_fwd;
    assign res_learn = q_q.res_learn;

    // helper terms for the checks
    logic chk_tcp;
    logic chk_set_miss;
    logic chk_unset_seen;
    assign chk_tcp = (frm.next_hdr == IPM_PROTO_TCP);
    always_comb begin
        chk_set_miss = 1'b0;
        chk_unset_seen = 1'b0;
        for (int i = 0; i < IPM_NUM_FLAGS; i++) begin
            if (ace.flag_sel[2*i +: 2] == IPM_FLAG_SET && !frm.tcp_flags[i])
                chk_set_miss = 1'b1;
            if (ace.flag_sel[2*i +: 2] == IPM_FLAG_UNSET && frm.tcp_flags[i]
                && chk_tcp)
                chk_unset_seen = 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_sport_range;
        frm_valid && ace.sp_mode == IPM_PORT_RANGE &&
        (frm.sport < ace.sp_lo || frm.sport > ace.sp_hi) |=> !res_hit;
    endproperty
    a_sport_range: assert property (p_sport_range) else $error("sport out");

    property p_dport_single;
        frm_valid && ace.dp_mode == IPM_PORT_SINGLE &&
        frm.dport != ace.dp_lo |=> !res_hit;
    endproperty
    a_dport_single: assert property (p_dport_single) else $error("dport");

    property p_flag_set;
        frm_valid && chk_set_miss |=> !res_hit;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("set flag");

    property p_flag_unset;
        frm_valid && chk_unset_seen |=> !res_hit;
    endproperty
    a_flag_unset: assert property (p_flag_unset) else $error("unset flag");

    property p_dscp;
        frm_valid && ace.tos_mode == IPM_TOS_DSCP &&
        frm.tclass[7:2] != ace.dscp |=> !res_hit;
    endproperty
    a_dscp: assert property (p_dscp) else $error("dscp mismatch hit");

    property p_prec;
        frm_valid && ace.tos_mode == IPM_TOS_PREC &&
        frm.tclass[7:5] != ace.prec |=> !res_hit;
    endproperty
    a_prec: assert property (p_prec) else $error("prec mismatch hit");

    property p_icmp_code;
        frm_valid && ace.code_en && frm.icmp_code != ace.icmp_code
        |=> !res_hit;
    endproperty
    a_icmp_code: assert property (p_icmp_code) else $error("code hit");

    property p_deny;
        res_hit |-> (res_drop == $past(ace.deny)) && (res_fwd != res_drop);
    endproperty
    a_deny: assert property (p_deny) else $error("deny verdict wrong");

    property p_permit;
        frm_valid && m_hit && !ace.deny |=> res_fwd && res_learn && !res_drop;
    endproperty
    a_permit: assert property (p_permit) else $error("permit verdict");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");

    c_deny: cover property (res_hit && res_drop);
    c_permit: cover property (res_hit && res_fwd);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);

endmodule

// File: tb/ipm_frm_src.sv
// frame source model standing in for the switch ports
`timescale 1ns/1ps
module ipm_frm_src
    import ipm_pkg::*;
(
    // clock
    input wire logic clk,
    // parsed frame out
    output logic frm_valid,
    output ipm_frame_s frm
);
    // quiet at time zero
    initial begin
        frm_valid = 1'b0;
        frm = '0;
    end

    // one frame per call; calls on successive edges go back to back
    task automatic send(input ipm_frame_s f);
        @(posedge clk);
        frm_valid <= 1'b1;
        frm <= f;
    endtask

    // between frames the fields toggle so stale data never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            frm_valid <= 1'b0;
            frm <= ~frm;
        end
    endtask
endmodule

// File: tb/testbench.sv
// self-checking bench of the ipv6 ace field matcher
`timescale 1ns/1ps
module testbench
    import ipm_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] s_axi_awaddr = '0;
    logic [7:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic frm_valid;
    ipm_frame_s frm;
    logic res_valid, res_hit, res_drop, res_fwd, res_learn;
    int n_mismatch = 0;
    int compares = 0;
    logic [31:0] seed = 32'hC330;
    logic [31:0] cw [7];
    logic [3:0] expq [$];
    logic [3:0] e;
    logic fv_d = 1'b0;
    logic [15:0] hits = '0;
    logic lh = 1'b0;
    logic ld = 1'b0;
    localparam logic [7:0] OFF [7] = '{IPM_OFF_CTRL, IPM_OFF_SPORT,
        IPM_OFF_DPORT, IPM_OFF_MODE, IPM_OFF_FLAGS, IPM_OFF_VALS,
        IPM_OFF_STAT};
    localparam logic [31:0] MSK [7] = '{32'h3, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFF, 32'hFFF, 32'hFFFF_073F, 32'h0};
    localparam logic [31:0] RV [7] = '{IPM_RST_CTRL, IPM_RST_SPORT,
        IPM_RST_DPORT, IPM_RST_MODE, IPM_RST_FLAGS, IPM_RST_VALS, 32'h0};

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end

    ipm_top DUT (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frm_valid, .frm,
        .res_valid, .res_hit, .res_drop, .res_fwd, .res_learn);

    ipm_frm_src src (.clk, .frm_valid, .frm);

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string nm);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // lfsr stepped a full word per call
    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
        return seed;
    endfunction

    // port criterion: any, single (low field) or inclusive range
    function automatic logic port_ok(logic [1:0] m, logic [31:0] w,
                                     logic [15:0] p);
        if (m == 2'h1) return p == w[15:0];
        if (m == 2'h2) return p >= w[15:0] && p <= w[31:16];
        return 1'b1;
    endfunction

    // reference verdict from the mirrored entry words
    function automatic logic mdl_hit(ipm_frame_s f);
        logic ok;
        logic tcp;
        int s;
        ok = cw[0][0];
        ok &= port_ok(cw[3][1:0], cw[1], f.sport);
        ok &= port_ok(cw[3][3:2], cw[2], f.dport);
        tcp = (f.next_hdr == IPM_PROTO_TCP);
        for (int i = 0; i < IPM_NUM_FLAGS; i++) begin
            s = cw[4][2*i +: 2];
            if (s == 1 && !(tcp && f.tcp_flags[i])) ok = 1'b0;
            if (s == 2 && tcp && f.tcp_flags[i]) ok = 1'b0;
        end
        if (cw[3][5:4] == 2'h1)
            ok &= f.tclass[7:2] == cw[5][5:0];
        if (cw[3][5:4] == 2'h2)
            ok &= f.tclass[7:5] == cw[5][10:8];
        if (cw[3][6]) ok &= f.next_hdr == cw[5][23:16];
        if (cw[3][7]) ok &= f.icmp_code == cw[5][31:24];
        return ok;
    endfunction

    // port value at or next to the configured bounds in half the draws, else random
    function automatic logic [15:0] pick(logic [31:0] w);
        logic [31:0] r;
        r = rnd();
        case (r[2:0])
            3'h0: return w[15:0];
            3'h1: return w[31:16];
            3'h2: return w[15:0] - 16'h1;
            3'h3: return w[31:16] + 16'h1;
            default: return r[31:16];
        endcase
    endfunction

    // axi4-lite write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no local limit: only the watchdog may end a stuck wait
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er, "bresp");
        s_axi_bready <= 1'b0;
    endtask

    // axi4-lite read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        // no local limit: only the watchdog may end a stuck wait
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // read one register and compare with the mirror
    task automatic rd_chk(input int i);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(OFF[i], d, r);
        chk(r, IPM_RESP_OKAY, "rresp");
        chk(d, (i == 6) ? {14'h0, ld, lh, hits} : cw[i], "register");
    endtask

    // one frame drawn near the entry, expectation queued first
    task automatic snd();
        ipm_frame_s f;
        logic [31:0] r;
        logic h;
        r = rnd();
        f.sport = pick(cw[1]);
        f.dport = pick(cw[2]);
        f.tcp_flags = r[5:0];
        f.next_hdr = (r[7:6] == 2'h0) ? cw[5][23:16] :
            (r[7] ? IPM_PROTO_TCP : r[15:8]);
        f.tclass = r[9] ? {cw[5][5:0], r[1:0]} :
            (r[10] ? {cw[5][10:8], r[4:0]} : r[23:16]);
        f.icmp_code = r[11] ? cw[5][31:24] : r[31:24];
        h = mdl_hit(f);
        expq.push_back({h, h & cw[0][1], !(h & cw[0][1]), !(h & cw[0][1])});
        hits += 16'(h);
        lh = h;
        ld = h & cw[0][1];
        src.send(f);
    endtask

    // verdict follows each frame by exactly one cycle
    always @(negedge clk) begin
        if (nrst) begin
            chk(res_valid, fv_d, "res_valid");
            if (res_valid === 1'b1 && expq.size() > 0) begin
                e = expq.pop_front();
                chk({res_hit, res_drop, res_fwd, res_learn}, e,
                    "verdict");
            end
            fv_d = frm_valid;
        end
    end

    // hang guard
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end

    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [31:0] raw;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // reset values
        for (int i = 0; i < 7; i++) begin
            if (i < 6) cw[i] = RV[i];
            rd_chk(i);
        end
        // unmapped place and read-only status
        axi_wr(8'h1C, rnd(), IPM_RESP_SLVERR);
        axi_rd(8'h1C, d, r);
        chk(r, IPM_RESP_SLVERR, "rresp unmapped");
        chk(d, 32'h0, "rdata unmapped");
        axi_wr(IPM_OFF_STAT, 32'hFFFF_FFFF, IPM_RESP_OKAY);
        rd_chk(6);
        // random entries, each hit by a burst of frames
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 6; i++) begin
                raw = rnd();
                if (i == 0) raw[0] = (k % 8 != 0);
                if ((i == 1 || i == 2) && k[0])
                    raw[31:16] = raw[15:0] + 16'(raw[18:16]);
                if (i == 4) raw &= rnd();
                cw[i] = raw & MSK[i];
                axi_wr(OFF[i], raw, IPM_RESP_OKAY);
                rd_chk(i);
            end
            repeat (8) snd();
            src.idle(3);
            rd_chk(6);
        end
        end_sim();
    end
endmodule
